/* gpio_bcd.sv */
// Design: three parallel I/O ports with alternate pin functions, Wishbone slave
//
// Implementation choice: register access over Wishbone.
`timescale 1ns/10ps

// Functional notes
// - Eight first-port latches, untouched by reset
// - Direction one drives pin; reset clears first
// - First-port read: latch if output, else pin
// - Latch writes always land; input reads pin
// - Converter-routed first pin reads zero if input
// - Converter pins: direction selects read, not buffer
// - Six second-port latches, untouched by reset
// - Clock-output enable drives system clock on pin2
// - Reset clears second direction and clock enable
// - Second-port read: latch if output, else pin; pin2 reads zero while clock output is enabled
// - Eight third-port latches; reset clears directions
// - Converter-routed third pin reads zero if input
// - Timer pins: direction selects read, not buffer
// - External timer clock takes third pins 6, 4
// - Third-port read: pin if input, else latch
module gpio_bcd (
  input  wire logic                     clk_i,
  input  wire logic                     rst_i,
  input  wire gpio_bcd_pkg::wb_req_t    wb_req_i,
  output logic [7:0]                    wb_dat_o,
  output logic                          wb_ack_o,
  input  wire gpio_bcd_pkg::port_pins_t pin_i,
  output gpio_bcd_pkg::port_pins_t      pin_o,
  output gpio_bcd_pkg::port_pins_t      pin_oe_n_o,
  output logic [4:0]                    converter_channel_select_o,
  output logic                          converter_enable_o,
  output logic                          timer_one_ext_clock_o,
  output logic                          timer_two_ext_clock_o
);

  // ==========================================================================
  // State
  // ==========================================================================
  logic [7:0] first_port_latch_q;
  logic [5:0] second_port_latch_q;
  logic [7:0] third_port_latch_q;
  logic [7:0] first_port_dir_q;
  logic [5:0] second_port_dir_q;
  logic       clock_out_enable_q;
  logic [7:0] third_port_dir_q;
  logic [4:0] converter_channel_select_q;
  logic [2:0] timer_one_prescale_select_q;
  logic [2:0] timer_two_prescale_select_q;
  logic       ack_q;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic       wr_en;
  logic       rd_en;

  // Single-cycle answer; ack drops in the cycle after it is given
  assign wr_en = wb_req_i.cyc && wb_req_i.stb && wb_req_i.we && wb_req_i.sel[0] && !ack_q;
  assign rd_en = wb_req_i.cyc && wb_req_i.stb && !ack_q;

  // ==========================================================================
  // Alternate-function ownership
  // ==========================================================================
  logic [7:0] first_conv;
  logic [7:0] third_conv;
  logic [7:0] third_timer;
  logic       t1_ext;
  logic       t2_ext;
  logic [4:0] ch_off;

  assign t1_ext = (timer_one_prescale_select_q == gpio_bcd_pkg::PS_EXT_CLOCK);
  assign t2_ext = (timer_two_prescale_select_q == gpio_bcd_pkg::PS_EXT_CLOCK);
  assign ch_off = converter_channel_select_q - gpio_bcd_pkg::THIRD_CH_BASE;

  always_comb begin
    first_conv  = 8'h00;
    third_conv  = 8'h00;
    third_timer = 8'h00;
    if (converter_channel_select_q < gpio_bcd_pkg::THIRD_CH_BASE) begin
      first_conv[converter_channel_select_q[2:0]] = 1'b1;
    end else if (converter_channel_select_q <= gpio_bcd_pkg::THIRD_CH_LAST) begin
      third_conv[ch_off[2:0]] = 1'b1;
    end
    third_timer[gpio_bcd_pkg::T1_CLK_PIN] = t1_ext;
    third_timer[gpio_bcd_pkg::T2_CLK_PIN] = t2_ext;
  end

  // ==========================================================================
  // Pin drivers
  // ==========================================================================
  genvar gi;
  generate
    for (gi = 0; gi < gpio_bcd_pkg::FIRST_WIDTH; gi++) begin : g_eight
      // Converter or timer use takes the buffer away from the direction bit
      assign pin_oe_n_o.first[gi] = !(first_port_dir_q[gi] && !first_conv[gi]);
      assign pin_o.first[gi]      = first_port_latch_q[gi];
      assign pin_oe_n_o.third[gi] =
        !(third_port_dir_q[gi] && !third_conv[gi] && !third_timer[gi]);
      assign pin_o.third[gi]      = third_port_latch_q[gi];
    end
    for (gi = 0; gi < gpio_bcd_pkg::SECOND_WIDTH; gi++) begin : g_six
      if (gi == gpio_bcd_pkg::CLK_OUT_PIN) begin : g_clk
        // Clock enable overrides the pin's direction bit
        assign pin_oe_n_o.second[gi] = !(clock_out_enable_q || second_port_dir_q[gi]);
        assign pin_o.second[gi]      = clock_out_enable_q ? clk_i
                                                          : second_port_latch_q[gi];
      end else begin : g_io
        assign pin_oe_n_o.second[gi] = !second_port_dir_q[gi];
        assign pin_o.second[gi]      = second_port_latch_q[gi];
      end
    end
  endgenerate

  // Timer clock inputs only follow the pin while selected
  assign timer_one_ext_clock_o = t1_ext && pin_i.third[gpio_bcd_pkg::T1_CLK_PIN];
  assign timer_two_ext_clock_o = t2_ext && pin_i.third[gpio_bcd_pkg::T2_CLK_PIN];
  assign converter_channel_select_o = converter_channel_select_q;
  assign converter_enable_o = (converter_channel_select_q <= gpio_bcd_pkg::THIRD_CH_LAST);

  // ==========================================================================
  // Data latches (no reset: contents survive system reset)
  // ==========================================================================
  always_ff @(posedge clk_i) begin
    if (wr_en && wb_req_i.adr == gpio_bcd_pkg::FIRST_PORT_DATA_ADDR) begin
      first_port_latch_q <= wb_req_i.dat;
    end
  end

  always_ff @(posedge clk_i) begin
    if (wr_en && wb_req_i.adr == gpio_bcd_pkg::SECOND_PORT_DATA_ADDR) begin
      second_port_latch_q <= wb_req_i.dat[5:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (wr_en && wb_req_i.adr == gpio_bcd_pkg::THIRD_PORT_DATA_ADDR) begin
      third_port_latch_q <= wb_req_i.dat;
    end
  end

  // ==========================================================================
  // Direction registers
  // ==========================================================================
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      first_port_dir_q <= gpio_bcd_pkg::DIR_RESET;
    end else if (wr_en && wb_req_i.adr == gpio_bcd_pkg::FIRST_PORT_DIR_ADDR) begin
      first_port_dir_q <= wb_req_i.dat;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      second_port_dir_q  <= gpio_bcd_pkg::DIR_RESET[5:0];
      clock_out_enable_q <= 1'b0;
    end else if (wr_en && wb_req_i.adr == gpio_bcd_pkg::SECOND_PORT_DIR_ADDR) begin
      second_port_dir_q  <= wb_req_i.dat[5:0];
      clock_out_enable_q <= wb_req_i.dat[gpio_bcd_pkg::CLK_OUT_BIT];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      third_port_dir_q <= gpio_bcd_pkg::DIR_RESET;
    end else if (wr_en && wb_req_i.adr == gpio_bcd_pkg::THIRD_PORT_DIR_ADDR) begin
      third_port_dir_q <= wb_req_i.dat;
    end
  end

  // ==========================================================================
  // Stand-ins for the converter and timer selection fields
  // ==========================================================================
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      converter_channel_select_q <= gpio_bcd_pkg::CH_RESET;
    end else if (wr_en && wb_req_i.adr == gpio_bcd_pkg::CONVERTER_CTRL_ADDR) begin
      converter_channel_select_q <= wb_req_i.dat[4:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      timer_one_prescale_select_q <= gpio_bcd_pkg::PS_RESET;
      timer_two_prescale_select_q <= gpio_bcd_pkg::PS_RESET;
    end else if (wr_en) begin
      if (wb_req_i.adr == gpio_bcd_pkg::TIMER_ONE_CTRL_ADDR) begin
        timer_one_prescale_select_q <= wb_req_i.dat[2:0];
      end
      if (wb_req_i.adr == gpio_bcd_pkg::TIMER_TWO_CTRL_ADDR) begin
        timer_two_prescale_select_q <= wb_req_i.dat[2:0];
      end
    end
  end

  // ==========================================================================
  // Read path
  // ==========================================================================
  always_comb begin
    rdata_d = gpio_bcd_pkg::UNMAPPED_READ;
    case (wb_req_i.adr)
      gpio_bcd_pkg::FIRST_PORT_DATA_ADDR: begin
        for (int i = 0; i < gpio_bcd_pkg::FIRST_WIDTH; i++) begin
          if (first_port_dir_q[i]) begin
            rdata_d[i] = first_port_latch_q[i];
          end else begin
            rdata_d[i] = first_conv[i] ? 1'b0 : pin_i.first[i];
          end
        end
      end
      gpio_bcd_pkg::SECOND_PORT_DATA_ADDR: begin
        for (int i = 0; i < gpio_bcd_pkg::SECOND_WIDTH; i++) begin
          rdata_d[i] = second_port_dir_q[i] ? second_port_latch_q[i]
                                            : pin_i.second[i];
        end
        if (clock_out_enable_q) begin
          rdata_d[gpio_bcd_pkg::CLK_OUT_PIN] = 1'b0;
        end
      end
      gpio_bcd_pkg::THIRD_PORT_DATA_ADDR: begin
        for (int i = 0; i < gpio_bcd_pkg::THIRD_WIDTH; i++) begin
          if (third_port_dir_q[i]) begin
            rdata_d[i] = third_port_latch_q[i];
          end else begin
            rdata_d[i] = third_conv[i] ? 1'b0 : pin_i.third[i];
          end
        end
      end
      gpio_bcd_pkg::FIRST_PORT_DIR_ADDR:  rdata_d = first_port_dir_q;
      gpio_bcd_pkg::SECOND_PORT_DIR_ADDR: begin
        rdata_d[5:0] = second_port_dir_q;
        rdata_d[gpio_bcd_pkg::CLK_OUT_BIT] = clock_out_enable_q;
      end
      gpio_bcd_pkg::THIRD_PORT_DIR_ADDR:  rdata_d = third_port_dir_q;
      gpio_bcd_pkg::CONVERTER_CTRL_ADDR:  rdata_d[4:0] = converter_channel_select_q;
      gpio_bcd_pkg::TIMER_ONE_CTRL_ADDR:  rdata_d[2:0] = timer_one_prescale_select_q;
      gpio_bcd_pkg::TIMER_TWO_CTRL_ADDR:  rdata_d[2:0] = timer_two_prescale_select_q;
      default:                            rdata_d = gpio_bcd_pkg::UNMAPPED_READ;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q   <= 1'b0;
      rdata_q <= 8'h00;
    end else begin
      ack_q <= rd_en;
      if (rd_en) begin
        rdata_q <= rdata_d;
      end
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdata_q;

endmodule // gpio_bcd

/* gpio_bcd_pkg.sv */
// Package: register map, field layout and carrier types for the parallel ports
package gpio_bcd_pkg;

  // ==========================================================================
  // Register map (byte addresses; printed data offsets, chosen direction ones)
  // ==========================================================================
  localparam logic [7:0] FIRST_PORT_DATA_ADDR  = 8'h01;
  localparam logic [7:0] SECOND_PORT_DATA_ADDR = 8'h02;
  localparam logic [7:0] THIRD_PORT_DATA_ADDR  = 8'h03;
  localparam logic [7:0] FIRST_PORT_DIR_ADDR   = 8'h05;
  localparam logic [7:0] SECOND_PORT_DIR_ADDR  = 8'h06;
  localparam logic [7:0] THIRD_PORT_DIR_ADDR   = 8'h07;
  localparam logic [7:0] CONVERTER_CTRL_ADDR   = 8'h08;
  localparam logic [7:0] TIMER_ONE_CTRL_ADDR   = 8'h09;
  localparam logic [7:0] TIMER_TWO_CTRL_ADDR   = 8'h0A;

  // ==========================================================================
  // Field layout
  // ==========================================================================
  localparam int unsigned FIRST_WIDTH   = 8;
  localparam int unsigned SECOND_WIDTH  = 6;
  localparam int unsigned THIRD_WIDTH   = 8;
  localparam int unsigned CLK_OUT_BIT   = 7;
  localparam int unsigned CLK_OUT_PIN   = 2;
  localparam int unsigned T1_CLK_PIN    = 6;
  localparam int unsigned T2_CLK_PIN    = 4;
  localparam int unsigned THIRD_ATD_PIN = 6;

  // Converter channels 0..7 on first port, 8..14 on third port
  localparam logic [4:0] FIRST_CH_BASE  = 5'h00;
  localparam logic [4:0] THIRD_CH_BASE  = 5'h08;
  localparam logic [4:0] THIRD_CH_LAST  = 5'h0E;
  localparam logic [2:0] PS_EXT_CLOCK   = 3'h7;

  // ==========================================================================
  // Reset values
  // ==========================================================================
  localparam logic [7:0] DIR_RESET      = 8'h00;
  localparam logic [4:0] CH_RESET       = 5'h1F;
  localparam logic [2:0] PS_RESET       = 3'h0;
  localparam logic [7:0] UNMAPPED_READ  = 8'h00;

  // ==========================================================================
  // Carriers
  // ==========================================================================
  typedef struct packed {
    logic [7:0] first;
    logic [5:0] second;
    logic [7:0] third;
  } port_pins_t;

  typedef struct packed {
    logic [7:0] adr;
    logic [7:0] dat;
    logic [3:0] sel;
    logic       we;
    logic       cyc;
    logic       stb;
  } wb_req_t;

endpackage

/* gpio_bcd_properties.sv */
// Checker: bus handshake and pin relations of the parallel ports
`timescale 1ns/10ps
module gpio_bcd_properties (
  input wire logic                     clk_i,
  input wire logic                     rst_i,
  input wire gpio_bcd_pkg::wb_req_t    wb_req_i,
  input wire logic [7:0]               wb_dat_o,
  input wire logic                     wb_ack_o,
  input wire gpio_bcd_pkg::port_pins_t pin_i,
  input wire gpio_bcd_pkg::port_pins_t pin_o,
  input wire gpio_bcd_pkg::port_pins_t pin_oe_n_o,
  input wire logic [4:0]               converter_channel_select_o,
  input wire logic                     converter_enable_o,
  input wire logic                     timer_one_ext_clock_o,
  input wire logic                     timer_two_ext_clock_o
);
  // ======
  // Taken requests
  // ======
  logic req;
  logic wr;
  assign req = wb_req_i.cyc && wb_req_i.stb && !wb_ack_o;
  assign wr  = req && wb_req_i.we && wb_req_i.sel[0];
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_ack_follows_req: assert property (req |=> wb_ack_o) else $error("ack missing");
  a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  a_reset_inputs: assert property ($fell(rst_i) |-> pin_oe_n_o == '1 && !wb_ack_o)
    else $error("pins not inputs after reset");
  a_unmapped_zero: assert property (req && !wb_req_i.we && wb_req_i.adr > 8'h0A
    |=> wb_dat_o == 8'h00) else $error("unmapped read not zero");
  a_first_read: assert property (req && !wb_req_i.we && wb_req_i.adr == 8'h01
    && !converter_enable_o |=> wb_dat_o == $past((pin_o.first & ~pin_oe_n_o.first)
    | (pin_i.first & pin_oe_n_o.first))) else $error("first port read wrong");
  a_latch_drives: assert property (wr && wb_req_i.adr == 8'h01
    |=> pin_o.first == $past(wb_req_i.dat)) else $error("latch not on pins");
  a_second_dir: assert property (wr && wb_req_i.adr == 8'h06
    |=> pin_oe_n_o.second == ~($past(wb_req_i.dat[5:0]) | {3'h0, $past(wb_req_i.dat[7]), 2'h0}))
    else $error("second port enables wrong");
  a_timer_clocks: assert property ((!timer_one_ext_clock_o || pin_i.third[6])
    && (!timer_two_ext_clock_o || pin_i.third[4])) else $error("timer clock not from pin");
  a_conv_enable: assert property (converter_enable_o == (converter_channel_select_o <= 5'h0E))
    else $error("converter enable wrong");
endmodule // gpio_bcd_properties

bind gpio_bcd gpio_bcd_properties u_gpio_bcd_properties (.clk_i, .rst_i, .wb_req_i, .wb_dat_o,
  .wb_ack_o, .pin_i, .pin_o, .pin_oe_n_o, .converter_channel_select_o, .converter_enable_o,
  .timer_one_ext_clock_o, .timer_two_ext_clock_o);

/* gpio_board_model.sv */
// Board model: levels seen on the port pins
`timescale 1ns/10ps
module gpio_board_model (
  input  wire gpio_bcd_pkg::port_pins_t port_out_i,
  input  wire gpio_bcd_pkg::port_pins_t port_oe_n_i,
  input  wire gpio_bcd_pkg::port_pins_t board_i,
  output gpio_bcd_pkg::port_pins_t      level_o
);
  // Released pins show the board's own drive, never the last port value
  assign level_o = gpio_bcd_pkg::port_pins_t'((port_oe_n_i & board_i) | (~port_oe_n_i & port_out_i));
endmodule // gpio_board_model

/* testbench.sv */
// Testbench: register access, pin behaviour and resets of the parallel ports
`timescale 1ns/10ps
module testbench;
  // ======
  // Signals and model state
  // ======
  logic                     clk_i;
  logic                     rst_i;
  gpio_bcd_pkg::wb_req_t    req;
  logic [7:0]               rdat;
  logic                     ack;
  gpio_bcd_pkg::port_pins_t pin_in, pin_out, oe_n, ext;
  logic [4:0]               ch_o;
  logic                     ce_o, t1_o, t2_o, clko;
  int                       errors, check_count;
  logic [7:0]               lat [3];
  logic [7:0]               dir [3];
  logic [2:0]               ps [2];
  logic [4:0]               ch;
  logic [7:0]               r, d;

  gpio_bcd u_gpio_bcd (.clk_i, .rst_i, .wb_req_i(req), .wb_dat_o(rdat), .wb_ack_o(ack),
    .pin_i(pin_in), .pin_o(pin_out), .pin_oe_n_o(oe_n), .converter_channel_select_o(ch_o),
    .converter_enable_o(ce_o), .timer_one_ext_clock_o(t1_o), .timer_two_ext_clock_o(t2_o));
  gpio_board_model u_gpio_board_model (.port_out_i(pin_out), .port_oe_n_i(oe_n), .board_i(ext),
    .level_o(pin_in));

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // ======
  // Helpers
  // ======
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic stop_test();
    if (errors == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // No count in the wait: only the watchdog ends a hung cycle
  task automatic bus(input logic [7:0] a, input logic [7:0] dd, input logic w, input logic [3:0] s);
    @(posedge clk_i);
    req <= '{a, dd, s, w, 1'b1, 1'b1};
    do @(posedge clk_i); while (ack !== 1'b1);
    r = rdat;
    req.cyc <= 1'b0;
    req.stb <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] dd, input logic [3:0] s);
    bus(a, dd, 1'b1, s);
    if (s[0]) case (a)
      8'h01: lat[0] = dd;
      8'h02: lat[1] = dd;
      8'h03: lat[2] = dd;
      8'h05: dir[0] = dd;
      8'h06: begin dir[1] = dd & 8'h3F; clko = dd[7]; end
      8'h07: dir[2] = dd;
      8'h08: ch = dd[4:0];
      8'h09: ps[0] = dd[2:0];
      8'h0A: ps[1] = dd[2:0];
      default: ;
    endcase
  endtask

  function automatic logic [7:0] port_rd(input int p);
    logic [7:0] v;
    v = (p == 0) ? ext.first : (p == 1) ? {2'h0, ext.second} : ext.third;
    v = (dir[p] & lat[p]) | (~dir[p] & v);
    if (p == 0 && ch < 5'h08) v[ch[2:0]] &= dir[0][ch[2:0]];
    if (p == 2 && ch >= 5'h08 && ch <= 5'h0E) v[ch[2:0]] &= dir[2][ch[2:0]];
    if (p == 1) v = {2'h0, v[5:3], v[2] & ~clko, v[1:0]};
    return v;
  endfunction

  function automatic logic [7:0] exp_rd(input logic [7:0] a);
    case (a)
      8'h01, 8'h02, 8'h03: return port_rd(int'(a) - 1);
      8'h05: return dir[0];
      8'h06: return {clko, 1'b0, dir[1][5:0]};
      8'h07: return dir[2];
      8'h08: return {3'h0, ch};
      8'h09: return {5'h0, ps[0]};
      8'h0A: return {5'h0, ps[1]};
      default: return 8'h00;
    endcase
  endfunction

  task automatic rd_chk(input logic [7:0] a);
    bus(a, 8'h00, 1'b0, 4'h1);
    check(r, exp_rd(a), "read");
  endtask

  task automatic pins();
    gpio_bcd_pkg::port_pins_t eo, m;
    eo = gpio_bcd_pkg::port_pins_t'(~{dir[0], dir[1][5:0], dir[2]});
    m = '1;
    if (clko) eo.second[2] = 1'b0;
    if (ps[0] == 3'h7) eo.third[6] = 1'b1;
    if (ps[1] == 3'h7) eo.third[4] = 1'b1;
    if (ch < 5'h08) m.first[ch[2:0]] = 1'b0;
    if (ch >= 5'h08 && ch <= 5'h0E) m.third[ch[2:0]] = 1'b0;
    check(oe_n & m, eo & m, "enables");
    m = gpio_bcd_pkg::port_pins_t'(m & ~eo);
    m.second[2] = m.second[2] & ~clko;
    check(pin_out & m, {lat[0], lat[1][5:0], lat[2]} & m, "levels");
    check({t1_o, t2_o}, {ps[0] == 3'h7 && ext.third[6], ps[1] == 3'h7 && ext.third[4]},
      "timer");
    check({ce_o, ch_o}, {ch <= 5'h0E, ch}, "select");
  endtask

  // ======
  // Sequence
  // ======
  initial begin
    rst_i = 1'b1;
    req = '0;
    ext = '0;
    errors = 0;
    check_count = 0;
    clko = 1'b0;
    ch = 5'h1F;
    ps = '{default: 3'h0};
    dir = '{default: 8'h00};
    void'($urandom(32'h3087));
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    pins();
    for (int a = 5; a <= 10; a++) rd_chk(8'(a));
    for (int i = 0; i < 48; i++) begin
      d = 8'($urandom);
      if (i % 3 == 1 && clko) d[2] = lat[1][2];
      wr(8'h01 + 8'(i % 3), d, 4'h1);
      wr(8'h05 + 8'(i % 3), 8'($urandom), 4'h1);
      wr(8'h08, (i % 16 == 15) ? 8'h1F : 8'(i % 16), 4'h1);
      wr(8'h09 + 8'(i % 2), 8'(i / 2), 4'h1);
      @(posedge clk_i) ext <= gpio_bcd_pkg::port_pins_t'(22'($urandom));
      rd_chk(8'h01 + 8'(i % 3));
      pins();
      rd_chk(8'h05 + 8'(i % 3));
    end
    wr(8'h10, 8'hFF, 4'h1);
    rd_chk(8'h10);
    wr(8'h05, 8'hFF, 4'h0);
    rd_chk(8'h05);
    // Mid-run reset: directions clear, latches kept
    @(posedge clk_i) rst_i <= 1'b1;
    @(posedge clk_i) rst_i <= 1'b0;
    dir = '{default: 8'h00};
    clko = 1'b0;
    ch = 5'h1F;
    ps = '{default: 3'h0};
    @(posedge clk_i);
    pins();
    for (int p = 0; p < 3; p++) begin
      wr(8'h05 + 8'(p), 8'h7F, 4'h1);
      rd_chk(8'h01 + 8'(p));
    end
    stop_test();
  end

  initial begin
    #100000;
    errors++;
    stop_test();
  end
endmodule // testbench
